// [hw/dsb_defines.vh]
// Register map constants for the staged input and broadcast load bank.
// Assumes byte addresses from the serial register port, 16-bit registers
// occupy two consecutive addresses.
`ifndef DSB_DEFINES_VH
`define DSB_DEFINES_VH

// ============================================================
// Addresses
`define DSB_ADDR_BCAST_VAL     8'hE6
`define DSB_ADDR_BCAST_SEL     8'hE8
`define DSB_ADDR_SOFT_TRIG     8'hE9
`define DSB_ADDR_STAGED_FIRST  8'hEA
`define DSB_ADDR_STAGED_LAST   8'hF8
`define DSB_ADDR_SOFT_MASK     8'hE4

// ============================================================
// Fields and reset values
`define DSB_TRIG_BIT           7
`define DSB_RST_BCAST_SEL      8'hFF
`define DSB_RST_SOFT_TRIG      8'h00
`define DSB_RST_STAGED         16'h0000
`define DSB_RST_BCAST_VAL      16'h0000
`define DSB_RST_SOFT_MASK      8'h00

`endif

// [hw/dsb_stage_mem.v]
// Eight-entry staged value store with registered read data.
// Assumes one masked write per cycle: a single channel or a masked write across all channels.
`timescale 1ns/10ps
`include "dsb_defines.vh"

module dsb_stage_mem #(
    parameter CH_N = 8,
    parameter DW   = 16
) (
    input  wire                 sys_clk_i,
    input  wire                 rstn_i,
    input  wire [CH_N-1:0]      wr_mask_i,
    input  wire [DW-1:0]        wr_data_i,
    input  wire [2:0]           rd_idx_i,
    output reg  [DW-1:0]        rd_data_o,
    output wire [CH_N*DW-1:0]   all_data_o
);

    reg [DW-1:0] mem_r [0:CH_N-1];
    integer      k;

    genvar g;
    generate
        for (g = 0; g < CH_N; g = g + 1) begin : g_flat
            assign all_data_o[g*DW +: DW] = mem_r[g];
        end
    endgenerate

    // ============================================================
    // Storage
    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            for (k = 0; k < CH_N; k = k + 1) begin
                mem_r[k] <= `DSB_RST_STAGED;
            end
            rd_data_o <= `DSB_RST_STAGED;
        end else begin
            for (k = 0; k < CH_N; k = k + 1) begin
                if (wr_mask_i[k]) begin
                    mem_r[k] <= wr_data_i;
                end
            end
            rd_data_o <= mem_r[rd_idx_i];
        end
    end

endmodule // dsb_stage_mem

// [hw/dsb_bank.v]
// Staged input, broadcast and software load register bank.
// Assumes a byte-addressed register port in the device clock domain; a 16-bit
// register is written as a whole word at its even address.
// Assumes one request per cycle: a write and a read never share a cycle.
// Assumes the hardware load strobe is a one-cycle pulse from the pin logic.
// Read data answer one cycle after the read request, with rvalid_o.
`timescale 1ns/10ps
`include "dsb_defines.vh"

// Operation
// - A broadcast write also stores its word into every selected staged channel.
// - A broadcast write leaves deselected staged channels unchanged.
// - A select bit of 1 includes its channel and 0 excludes it.
// - All select bits reset to 1.
// - Writing 1 to trigger bit 7 copies enabled staged values to active values.
// - Writing 0 to the trigger bit does nothing.
// - On a software trigger with no hardware strobe in the same cycle, only channels enabled in the soft load mask are loaded.
// - The trigger register is at 0xE9 and resets to 0x00.
// - Eight read/write staged registers sit at 0xEA to 0xF8 step 2, reset 0x0000.
// - Writing a staged register leaves the active value unchanged.
// - Loading an active value also updates the channel output code.
// - The broadcast value register at 0xE6 reads back the last written word.
// - The select register sits at 0xE8, resets to 0xFF, one bit per channel.
module dsb_bank #(
    parameter CH_N = 8,
    parameter DW   = 16
) (
    input  wire                 sys_clk_i,
    input  wire                 rstn_i,
    input  wire                 wr_en_i,
    input  wire                 rd_en_i,
    input  wire [7:0]           addr_i,
    input  wire [DW-1:0]        wdata_i,
    input  wire                 load_strobe_i,
    output reg  [DW-1:0]        rdata_o,
    output reg                  rvalid_o,
    output wire [CH_N*DW-1:0]   active_converter_value_o,
    output reg  [CH_N-1:0]      out_update_o
);

    reg  [DW-1:0]       broadcast_input_value_r;
    reg  [CH_N-1:0]     broadcast_input_select_r;
    reg  [CH_N-1:0]     soft_load_channel_mask_r;
    reg  [DW-1:0]       active_r [0:CH_N-1];
    reg  [CH_N-1:0]     stage_mask_nxt;
    reg  [DW-1:0]       stage_data_nxt;
    reg  [CH_N-1:0]     load_mask_nxt;
    reg  [DW-1:0]       rdata_nxt;
    reg                 stage_rd_r;
    reg  [DW-1:0]       rdata_hold_r;
    wire [DW-1:0]       stage_rd_data;
    wire [CH_N*DW-1:0]  stage_all;
    wire                staged_hit;
    wire [2:0]          staged_idx;
    wire [7:0]          staged_off;
    wire                sel_bcast_val;
    wire                sel_bcast_sel;
    wire                sel_soft_mask;
    wire                sel_soft_trig;
    wire                wr_bcast_val;
    wire                wr_bcast_sel;
    wire                wr_soft_mask;
    wire                wr_soft_trig;
    wire                trig_fire;
    wire                rd_staged;
    reg  [CH_N-1:0]     soft_load_nxt;
    integer             k;

    // Channel index of a staged address
    function [2:0] dsb_idx;
        input [7:0] a;
        reg   [7:0] d;
        begin
            d = a - `DSB_ADDR_STAGED_FIRST;
            dsb_idx = d[3:1];
        end
    endfunction

    assign staged_off = addr_i - `DSB_ADDR_STAGED_FIRST;
    assign staged_hit = (addr_i >= `DSB_ADDR_STAGED_FIRST) &&
                        (addr_i <= `DSB_ADDR_STAGED_LAST) && !staged_off[0];
    assign staged_idx = dsb_idx(addr_i);

    genvar g;
    generate
        for (g = 0; g < CH_N; g = g + 1) begin : g_act
            assign active_converter_value_o[g*DW +: DW] = active_r[g];
        end
    endgenerate

    // ============================================================
    // Register selects
    function dsb_is;
        input [7:0] a;
        input [7:0] b;
        begin
            dsb_is = (a == b);
        end
    endfunction

    assign sel_bcast_val = dsb_is(addr_i, `DSB_ADDR_BCAST_VAL);
    assign sel_bcast_sel = dsb_is(addr_i, `DSB_ADDR_BCAST_SEL);
    assign sel_soft_mask = dsb_is(addr_i, `DSB_ADDR_SOFT_MASK);
    assign sel_soft_trig = dsb_is(addr_i, `DSB_ADDR_SOFT_TRIG);
    assign wr_bcast_val  = wr_en_i && sel_bcast_val;
    assign wr_bcast_sel  = wr_en_i && sel_bcast_sel;
    assign wr_soft_mask  = wr_en_i && sel_soft_mask;
    assign wr_soft_trig  = wr_en_i && sel_soft_trig;
    assign rd_staged     = rd_en_i && staged_hit;
    assign trig_fire     = wr_soft_trig && wdata_i[`DSB_TRIG_BIT];

    // ============================================================
    // Staged write decode
    always @* begin
        stage_mask_nxt = {CH_N{1'b0}};
        stage_data_nxt = wdata_i;
        if (wr_bcast_val) begin
            stage_mask_nxt = broadcast_input_select_r;
        end else if (wr_en_i && staged_hit) begin
            stage_mask_nxt[staged_idx] = 1'b1;
        end
    end

    dsb_stage_mem #(
        .CH_N (CH_N),
        .DW   (DW)
    ) u_mem (
        .sys_clk_i  (sys_clk_i),
        .rstn_i     (rstn_i),
        .wr_mask_i  (stage_mask_nxt),
        .wr_data_i  (stage_data_nxt),
        .rd_idx_i   (staged_idx),
        .rd_data_o  (stage_rd_data),
        .all_data_o (stage_all)
    );

    // ============================================================
    // Load decode
    always @* begin
        soft_load_nxt = {CH_N{1'b0}};
        if (trig_fire) begin
            soft_load_nxt = soft_load_channel_mask_r;
        end
    end

    always @* begin
        // hardware strobe loads all channels and wins
        if (load_strobe_i) begin
            load_mask_nxt = {CH_N{1'b1}};
        end else begin
            load_mask_nxt = soft_load_nxt;
        end
    end

    // ============================================================
    // Broadcast value register
    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            broadcast_input_value_r <= `DSB_RST_BCAST_VAL;
        end else if (wr_bcast_val) begin
            broadcast_input_value_r <= wdata_i;
        end
    end

    // ============================================================
    // Broadcast select register
    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            broadcast_input_select_r <= `DSB_RST_BCAST_SEL;
        end else if (wr_bcast_sel) begin
            broadcast_input_select_r <= wdata_i[CH_N-1:0];
        end
    end

    // ============================================================
    // Soft load channel mask
    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            soft_load_channel_mask_r <= `DSB_RST_SOFT_MASK;
        end else if (wr_soft_mask) begin
            soft_load_channel_mask_r <= wdata_i[CH_N-1:0];
        end
    end

    // ============================================================
    // Active values
    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            for (k = 0; k < CH_N; k = k + 1) begin
                active_r[k] <= `DSB_RST_STAGED;
            end
        end else begin
            for (k = 0; k < CH_N; k = k + 1) begin
                if (load_mask_nxt[k]) begin
                    active_r[k] <= stage_all[k*DW +: DW];
                end
            end
        end
    end

    // ============================================================
    // Output update pulses
    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            out_update_o <= {CH_N{1'b0}};
        end else begin
            out_update_o <= load_mask_nxt;
        end
    end

    // ============================================================
    // Read path
    function [DW-1:0] dsb_pad;
        input [CH_N-1:0] v;
        begin
            dsb_pad = {{(DW-CH_N){1'b0}}, v};
        end
    endfunction

    always @* begin
        rdata_nxt = {DW{1'b0}};
        if (sel_bcast_val) begin
            rdata_nxt = broadcast_input_value_r;
        end else if (sel_bcast_sel) begin
            rdata_nxt = dsb_pad(broadcast_input_select_r);
        end else if (sel_soft_mask) begin
            rdata_nxt = dsb_pad(soft_load_channel_mask_r);
        end else if (sel_soft_trig) begin
            rdata_nxt = dsb_pad(`DSB_RST_SOFT_TRIG);
        end
    end

    // ============================================================
    // Read answer registers
    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_en_i;
        end
    end

    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            stage_rd_r <= 1'b0;
        end else begin
            stage_rd_r <= rd_staged;
        end
    end

    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rdata_hold_r <= {DW{1'b0}};
        end else begin
            rdata_hold_r <= rdata_nxt;
        end
    end

    // Staged words come straight from the store's read register
    always @* begin
        rdata_o = stage_rd_r ? stage_rd_data : rdata_hold_r;
    end

endmodule // dsb_bank

// [tb/dsb_bank_chk.sv]
// Timing checker for the staged input bank.
// Assumes binding to dsb_bank, one clock domain.
`timescale 1ns/10ps
module dsb_bank_chk #(
    parameter CH_N = 8,
    parameter DW   = 16
) (
    input wire                sys_clk_i,
    input wire                rstn_i,
    input wire                wr_en_i,
    input wire                rd_en_i,
    input wire [7:0]          addr_i,
    input wire [DW-1:0]       wdata_i,
    input wire                load_strobe_i,
    input wire [DW-1:0]       rdata_o,
    input wire                rvalid_o,
    input wire [CH_N*DW-1:0]  active_converter_value_o,
    input wire [CH_N-1:0]     out_update_o
);
    // ============================================================
    // Assertions
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    wire trig = wr_en_i && addr_i == 8'hE9;
    wire go   = load_strobe_i || (trig && wdata_i[7]);
    a_read_answer: assert property (rd_en_i |=> rvalid_o) else $error("no rvalid");
    a_read_cause: assert property (rvalid_o |-> $past(rd_en_i)) else $error("stray rvalid");
    a_trig_reads_zero: assert property (rd_en_i && addr_i == 8'hE9 |=> rdata_o == '0)
        else $error("trigger read");
    a_strobe_all: assert property (load_strobe_i |=> &out_update_o) else $error("strobe");
    a_trig_zero_idle: assert property (trig && !wdata_i[7] && !load_strobe_i |=>
        out_update_o == '0) else $error("zero trigger");
    a_staged_no_load: assert property (wr_en_i && addr_i >= 8'hEA && !load_strobe_i |=>
        out_update_o == '0) else $error("staged load");
    a_update_cause: assert property (|out_update_o |-> $past(go)) else $error("no cause");
    a_value_update: assert property (!$stable(active_converter_value_o) |->
        |out_update_o) else $error("silent change");
endmodule // dsb_bank_chk

bind dsb_bank dsb_bank_chk #(.CH_N(CH_N), .DW(DW)) u_chk (.*);

// [tb/dsb_host.sv]
// Host model driving the register port.
// Assumes requests are taken at the rising edge.
`timescale 1ns/10ps
module dsb_host (
    input  wire          sys_clk_i,
    input  wire          rvalid_i,
    input  wire  [15:0]  rdata_i,
    output logic         wr_en_o = 1'b0,
    output logic         rd_en_o = 1'b0,
    output logic [7:0]   addr_o = 8'h00,
    output logic [15:0]  wdata_o = 16'h0000,
    output logic         load_o = 1'b0
);
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        wr_en_o <= 1'b1;
        addr_o  <= a;
        wdata_o <= d;
        @(posedge sys_clk_i);
        wr_en_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk_i);
        rd_en_o <= 1'b1;
        addr_o  <= a;
        @(posedge sys_clk_i);
        rd_en_o <= 1'b0;
        @(posedge sys_clk_i);
        d = rvalid_i ? rdata_i : 16'hXXXX;
    endtask
    task automatic strobe;
        @(posedge sys_clk_i);
        load_o <= 1'b1;
        @(posedge sys_clk_i);
        load_o <= 1'b0;
    endtask
endmodule // dsb_host

// [tb/tb.sv]
// Testbench of the staged input bank.
// Assumes the host model drives the port.
`timescale 1ns/10ps
module tb;
    logic          sys_clk_i = 1'b0;
    logic          rstn_i = 1'b0;
    wire           wr_en_i, rd_en_i, load_strobe_i, rvalid_o;
    wire  [7:0]    addr_i, out_update_o;
    wire  [15:0]   wdata_i, rdata_o;
    wire  [127:0]  active_converter_value_o;
    logic [127:0]  e;
    logic [15:0]   d;
    int            mismatches = 0;
    int            n_tests = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    dsb_host host (.sys_clk_i(sys_clk_i), .rvalid_i(rvalid_o), .rdata_i(rdata_o),
        .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i),
        .load_o(load_strobe_i));
    dsb_bank DUT (.*);
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h", $time, got);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] x);
        host.rd(a, d);
        chk(d, x);
    endtask
    task automatic t_bcast;
        rc(8'hE8, 16'h00FF);
        rc(8'hE9, 16'h0000);
        host.wr(8'hE6, 16'h1234);
        rc(8'hE6, 16'h1234);
        for (int i = 0; i < 8; i++) rc(8'hEA + 8'(2 * i), 16'h1234);
        host.wr(8'hE8, 16'h0005);
        rc(8'hE8, 16'h0005);
        host.wr(8'hE6, 16'hABCD);
        for (int i = 0; i < 8; i++) rc(8'hEA + 8'(2 * i), i % 2 == 0 && i < 4 ? 16'hABCD : 16'h1234);
        $display("test broadcast done");
    endtask
    task automatic t_soft;
        for (int i = 0; i < 8; i++) host.wr(8'hEA + 8'(2 * i), 16'hA500 + 16'(i));
        for (int i = 0; i < 8; i++) rc(8'hEA + 8'(2 * i), 16'hA500 + 16'(i));
        chk(active_converter_value_o, '0);
        host.wr(8'hE4, 16'h0081);
        host.wr(8'hE9, 16'h007F);
        @(posedge sys_clk_i);
        chk(out_update_o, 8'h00);
        rc(8'hE9, 16'h0000);
        host.wr(8'hE9, 16'h0080);
        @(posedge sys_clk_i);
        chk(out_update_o, 8'h81);
        chk(active_converter_value_o, {16'hA507, 96'h0, 16'hA500});
        $display("test soft load done");
    endtask
    task automatic t_strobe;
        for (int i = 0; i < 8; i++) e[16 * i +: 16] = 16'hA500 + 16'(i);
        host.strobe;
        @(posedge sys_clk_i);
        chk(out_update_o, 8'hFF);
        chk(active_converter_value_o, e);
        $display("test strobe done");
    endtask
    task automatic t_misc;
        host.wr(8'hEB, 16'h5A5A);
        rc(8'hEA, 16'hA500);
        rc(8'hE7, 16'h0000);
        @(posedge sys_clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        chk(active_converter_value_o, '0);
        rc(8'hE8, 16'h00FF);
        rc(8'hEA, 16'h0000);
        $display("test misc done");
    endtask
    task automatic report_and_stop;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        t_bcast;
        t_soft;
        t_strobe;
        t_misc;
        report_and_stop;
    end
    initial begin
        #100000;
        mismatches++;
        report_and_stop;
    end
endmodule // tb
